// ---- verilog/sac_pkg.sv ----
/*
  Shared constants, state codes and the lane-order function for the converter
  control link. Assumes a 200 MHz system clock common to both ends.
*/
`default_nettype none

package sac_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_START_NS = 40;     // Least start pulse
  localparam int T_SETUP_NS = 10;     // Least read/convert setup before select
  localparam int T_CONV_NS = 2300;    // Typical conversion time
  localparam int T_ACQ_NS = 1000;     // Typical acquisition interval
  localparam int START_CYC = (T_START_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC = (T_CONV_NS * CLK_MHZ) / 1000;
  localparam int ACQ_CYC = (T_ACQ_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam int SAR_BITS = 16;
  localparam int STEP_CYC = CONV_CYC / SAR_BITS;
  localparam int LANE_WAIT_CYC = 2;   // Byte select to settled data lanes
  localparam logic [3:0] MSB_IDX = 4'hF;
  localparam logic [RESULT_W-1:0] SIGN_FLIP = 16'h8000;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h1,
    DEV_CONV = 3'h2,
    DEV_LOAD = 3'h4
  } sac_dev_e;

  typedef enum logic [7:0] {
    HST_IDLE = 8'h01,
    HST_SETUP = 8'h02,
    HST_START = 8'h04,
    HST_WFALL = 8'h08,
    HST_WRISE = 8'h10,
    HST_READ = 8'h20,
    HST_READ2 = 8'h40,
    HST_ACQ = 8'h80
  } sac_host_e;

  // Upper and lower byte lanes, swapped when asked
  function automatic logic [RESULT_W-1:0] sac_lane_order(
    input logic [RESULT_W-1:0] word,
    input logic swap
  );
    if (swap)
    begin
      return {word[BYTE_W-1:0], word[RESULT_W-1:BYTE_W]};
    end
    return word;
  endfunction : sac_lane_order

endpackage : sac_pkg

`default_nettype wire

// ---- verilog/sac_link_if.sv ----
/*
  Link between host and converter ends. Assumes both ends run on sys_clk;
  the bench checks resultOe against select and read/convert.
*/
`timescale 1ns/1ps
`default_nettype none

interface sac_link_if;
  logic csN;
  logic rdConv;
  logic byteSel;
  logic convBusyN;
  logic [sac_pkg::RESULT_W-1:0] resultBus;
  logic resultOe;

  // Converter end
  modport device(
    input csN,
    input rdConv,
    input byteSel,
    output convBusyN,
    output resultBus,
    output resultOe
  );

  // Host end
  modport host(
    output csN,
    output rdConv,
    output byteSel,
    input convBusyN,
    input resultBus,
    input resultOe
  );
endinterface : sac_link_if

`default_nettype wire

// ---- verilog/sac_device_end.sv ----
/*
  Converter end: start detection, internally timed successive approximation,
  result latch and byte-lane output with enable. Assumes the host drives the
  link from logic on the same sys_clk, so link inputs are read directly.
*/
`timescale 1ns/1ps
`default_nettype none

module sac_device_end #(
  parameter int STEP_CYC = sac_pkg::STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  sac_link_if.device link,
  input wire logic [sac_pkg::RESULT_W-1:0] sampleIn,
  output logic convActive,
  output logic [sac_pkg::RESULT_W-1:0] lastResult
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int STEP_W = $clog2(STEP_CYC + 1);
  localparam int RW = sac_pkg::RESULT_W;

  typedef struct packed {
    sac_pkg::sac_dev_e st;
    logic prevReq;
    logic [RW-1:0] held;
    logic [RW-1:0] trial;
    logic [3:0] bitIdx;
    logic [STEP_W-1:0] stepCnt;
    logic [RW-1:0] result;
    logic [RW-1:0] dataOut;
    logic busyN;
  } sac_dev_s;

  localparam sac_dev_s DEV_RST = '{
    st: sac_pkg::DEV_IDLE,
    prevReq: 1'b0,
    held: sac_pkg::RESULT_RST,
    trial: sac_pkg::RESULT_RST,
    bitIdx: sac_pkg::MSB_IDX,
    stepCnt: '0,
    result: sac_pkg::RESULT_RST,
    dataOut: sac_pkg::RESULT_RST,
    busyN: 1'b1
  };

  localparam logic [RW-1:0] ONE_BIT = {{(RW-1){1'b0}}, 1'b1};

  sac_dev_s s;
  sac_dev_s next_s;
  logic reqLow;

  // ----------------------------------------------------------------
  // Start request decode
  // ----------------------------------------------------------------

  // Select and read/convert are ORed; both low is a start request
  assign reqLow = ~link.csN & ~link.rdConv;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Conversion sequencer and output data path
  always_comb
  begin
    logic [RW-1:0] cand;
    cand = sac_pkg::RESULT_RST;
    next_s = s;
    next_s.prevReq = reqLow;
    // Lane order follows byte select, data held in flops
    next_s.dataOut = sac_pkg::sac_lane_order(s.result, link.byteSel);
    case (s.st)
      sac_pkg::DEV_IDLE:
      begin
        next_s.busyN = 1'b1;
        // Falling edge of the combined request holds the sample
        if (reqLow && !s.prevReq)
        begin
          next_s.held = sampleIn;
          next_s.trial = sac_pkg::RESULT_RST;
          next_s.bitIdx = sac_pkg::MSB_IDX;
          next_s.stepCnt = STEP_W'(STEP_CYC - 1);
          next_s.busyN = 1'b0;
          next_s.st = sac_pkg::DEV_CONV;
        end
      end
      sac_pkg::DEV_CONV:
      begin
        // Further requests have no effect here
        next_s.busyN = 1'b0;
        if (s.stepCnt != '0)
        begin
          next_s.stepCnt = s.stepCnt - 1'b1;
        end
        else
        begin
          // Trial bit kept if it does not exceed the offset sample
          cand = s.trial | (ONE_BIT << s.bitIdx);
          if (cand <= (s.held ^ sac_pkg::SIGN_FLIP))
          begin
            next_s.trial = cand;
          end
          next_s.stepCnt = STEP_W'(STEP_CYC - 1);
          if (s.bitIdx == 4'h0)
          begin
            next_s.st = sac_pkg::DEV_LOAD;
          end
          else
          begin
            next_s.bitIdx = s.bitIdx - 4'h1;
          end
        end
      end
      sac_pkg::DEV_LOAD:
      begin
        // Offset code back to two's complement; busy rises one edge after the result loads
        next_s.result = s.trial ^ sac_pkg::SIGN_FLIP;
        next_s.busyN = 1'b0;
        next_s.st = sac_pkg::DEV_IDLE;
      end
      default:
      begin
        next_s = DEV_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Single state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s <= DEV_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Link outputs; enable is combinational so release is immediate
  assign link.convBusyN = s.busyN;
  assign link.resultBus = s.dataOut;
  assign link.resultOe = nrst & ~link.csN & link.rdConv;

  // User-side status
  assign convActive = ~s.busyN;
  assign lastResult = s.result;

endmodule : sac_device_end

`default_nettype wire

// ---- verilog/sac_host_end.sv ----
/*
  Host end: drives select, read/convert and byte select through a start,
  waits on busy, reads the result as a word or two bytes, then waits out the
  acquisition interval. Assumes the converter end shares sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sac_host_end #(
  parameter int START_CYC = sac_pkg::START_CYC,
  parameter int SETUP_CYC = sac_pkg::SETUP_CYC,
  parameter int ACQ_CYC = sac_pkg::ACQ_CYC,
  parameter int LANE_WAIT_CYC = sac_pkg::LANE_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  sac_link_if.host link,
  input wire logic startReq,
  input wire logic useCsMode,
  input wire logic byteRead,
  output logic hostReady,
  output logic [sac_pkg::RESULT_W-1:0] sampleWord,
  output logic wordValid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(ACQ_CYC + START_CYC + SETUP_CYC + LANE_WAIT_CYC + 1);
  localparam int RW = sac_pkg::RESULT_W;
  localparam int BW = sac_pkg::BYTE_W;

  typedef struct packed {
    sac_pkg::sac_host_e st;
    logic csN;
    logic rdConv;
    logic byteSel;
    logic mode2;
    logic bytes;
    logic [CNT_W-1:0] cnt;
    logic [BW-1:0] hiByte;
    logic [RW-1:0] word;
    logic valid;
  } sac_host_s;

  localparam sac_host_s HST_RST = '{
    st: sac_pkg::HST_IDLE,
    csN: 1'b1,
    rdConv: 1'b1,
    byteSel: 1'b0,
    mode2: 1'b0,
    bytes: 1'b0,
    cnt: '0,
    hiByte: '0,
    word: sac_pkg::RESULT_RST,
    valid: 1'b0
  };

  sac_host_s s;
  sac_host_s next_s;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Start, wait, read and acquisition sequence
  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    if (s.cnt != '0)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
    case (s.st)
      sac_pkg::HST_IDLE:
      begin
        next_s.csN = useCsMode;
        next_s.rdConv = 1'b1;
        next_s.byteSel = 1'b0;
        // Take a start only once select has settled at the mode level
        if (startReq && (s.csN == useCsMode))
        begin
          next_s.mode2 = useCsMode;
          next_s.bytes = byteRead;
          next_s.rdConv = 1'b0;
          if (useCsMode)
          begin
            next_s.cnt = CNT_W'(SETUP_CYC - 1);
            next_s.st = sac_pkg::HST_SETUP;
          end
          else
          begin
            next_s.cnt = CNT_W'(START_CYC - 1);
            next_s.st = sac_pkg::HST_START;
          end
        end
      end
      sac_pkg::HST_SETUP:
      begin
        if (s.cnt == '0)
        begin
          next_s.csN = 1'b0;
          next_s.cnt = CNT_W'(START_CYC - 1);
          next_s.st = sac_pkg::HST_START;
        end
      end
      sac_pkg::HST_START:
      begin
        // Release well inside the 1us window
        if (s.cnt == '0)
        begin
          next_s.rdConv = 1'b1;
          next_s.csN = s.mode2;
          next_s.st = sac_pkg::HST_WFALL;
        end
      end
      sac_pkg::HST_WFALL:
      begin
        if (!link.convBusyN)
        begin
          next_s.st = sac_pkg::HST_WRISE;
        end
      end
      sac_pkg::HST_WRISE:
      begin
        // An input is high at busy rise, so no restart
        if (link.convBusyN)
        begin
          next_s.csN = 1'b0;
          next_s.st = sac_pkg::HST_READ;
        end
      end
      sac_pkg::HST_READ:
      begin
        next_s.word = link.resultBus;
        next_s.hiByte = link.resultBus[RW-1:BW];
        if (s.bytes)
        begin
          next_s.byteSel = 1'b1;
          next_s.cnt = CNT_W'(LANE_WAIT_CYC - 1);
          next_s.st = sac_pkg::HST_READ2;
        end
        else
        begin
          next_s.valid = 1'b1;
          next_s.csN = s.mode2;
          next_s.cnt = CNT_W'(ACQ_CYC - 1);
          next_s.st = sac_pkg::HST_ACQ;
        end
      end
      sac_pkg::HST_READ2:
      begin
        // Low byte arrives on the upper lanes
        if (s.cnt == '0)
        begin
          next_s.word = {s.hiByte, link.resultBus[RW-1:BW]};
          next_s.valid = 1'b1;
          next_s.byteSel = 1'b0;
          next_s.csN = s.mode2;
          next_s.cnt = CNT_W'(ACQ_CYC - 1);
          next_s.st = sac_pkg::HST_ACQ;
        end
      end
      sac_pkg::HST_ACQ:
      begin
        if (s.cnt == '0)
        begin
          next_s.st = sac_pkg::HST_IDLE;
        end
      end
      default:
      begin
        next_s = HST_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Single state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s <= HST_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.csN = s.csN;
  assign link.rdConv = s.rdConv;
  assign link.byteSel = s.byteSel;
  assign hostReady = (s.st == sac_pkg::HST_IDLE) && (s.csN == useCsMode); // Mode settled
  assign sampleWord = s.word;
  assign wordValid = s.valid;

endmodule : sac_host_end

`default_nettype wire

// ---- sim/sac_link_checker.sv ----
/*
  Assertions on the link between host and converter ends.
  Assumes plain link signals on one sys_clk domain, reset nrst active low.
*/
`timescale 1ns/1ps
`default_nettype none

module sac_link_checker #(
  parameter int STEP_CYC = sac_pkg::STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic rdConv,
  input wire logic byteSel,
  input wire logic convBusyN,
  input wire logic [sac_pkg::RESULT_W-1:0] resultBus,
  input wire logic resultOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam logic [11:0] CONV_LEN = 12'(16 * STEP_CYC + 2);
  logic convReq;
  logic [11:0] lowCnt;

  // Combined start request
  assign convReq = ~csN & ~rdConv;

  // Cycles with busy low
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || convBusyN)
      lowCnt <= 12'h000;
    else
      lowCnt <= lowCnt + 12'h001;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  start_to_busy_a: assert property (convReq && !$past(convReq) && convBusyN
    |=> !convBusyN) else $error("busy did not fall after a start");
  busy_width_a: assert property ($rose(convBusyN)
    |-> lowCnt == CONV_LEN) else $error("busy low time wrong");
  busy_cause_a: assert property ($fell(convBusyN)
    |-> $past(convReq) && !$past(convReq, 2)) else $error("busy fell without a start");
  hiz_convert_a: assert property (!rdConv |-> !resultOe)
    else $error("data driven while convert low");
  read_enable_a: assert property (!csN && rdConv |-> resultOe)
    else $error("data not enabled for a read");
  lane_swap_a: assert property ($changed(byteSel) && convBusyN && $past(convBusyN)
    |=> resultBus == {$past(resultBus[7:0]), $past(resultBus[15:8])})
    else $error("byte lanes not swapped");
  quiet_at_rise_a: assert property ($rose(convBusyN) |-> csN || rdConv)
    else $error("start request held at busy rise");
  start_hold_a: assert property (convReq && !$past(convReq) |-> convReq[*8])
    else $error("start pulse too short");
  start_release_a: assert property (convReq && !$past(convReq)
    |-> ##[8:200] !convReq) else $error("start not released in time");
  setup_a: assert property ($fell(csN) && !rdConv
    |-> !$past(rdConv) && !$past(rdConv, 2)) else $error("convert setup too short");

  // Main scenarios
  mode_one_c: cover property ($fell(rdConv) && !csN);
  mode_two_c: cover property ($fell(csN) && !rdConv);
  byte_read_c: cover property ($rose(byteSel) && convBusyN);
endmodule : sac_link_checker

`default_nettype wire

// ---- sim/tb_sar_adc_conversion_read_control.sv ----
/*
  Self-checking bench joining host and converter ends through the link.
  Assumes sys_clk at 200 MHz and small step and acquisition counts.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sar_adc_conversion_read_control;
  localparam int STEP = 2;
  localparam logic [15:0] CONV_LEN = 16'(16 * STEP + 2);
  logic sys_clk;
  logic nrst;
  logic [15:0] sampleIn;
  logic convActive;
  logic [15:0] lastResult;
  logic startReq;
  logic useCsMode;
  logic byteRead;
  logic hostReady;
  logic [15:0] sampleWord;
  logic wordValid;
  int err_total;
  int compares;

  // ----------------------------------------------------------------
  // Design, link and checker
  // ----------------------------------------------------------------
  sac_link_if i_sac_link_if();
  sac_device_end #(.STEP_CYC(STEP)) i_sac_device_end (.sys_clk(sys_clk), .nrst(nrst),
    .link(i_sac_link_if), .sampleIn(sampleIn), .convActive(convActive),
    .lastResult(lastResult));
  sac_host_end #(.ACQ_CYC(4)) i_sac_host_end (.sys_clk(sys_clk), .nrst(nrst),
    .link(i_sac_link_if), .startReq(startReq), .useCsMode(useCsMode),
    .byteRead(byteRead), .hostReady(hostReady), .sampleWord(sampleWord),
    .wordValid(wordValid));
  sac_link_checker #(.STEP_CYC(STEP)) i_sac_link_checker (.sys_clk(sys_clk),
    .nrst(nrst), .csN(i_sac_link_if.csN), .rdConv(i_sac_link_if.rdConv),
    .byteSel(i_sac_link_if.byteSel), .convBusyN(i_sac_link_if.convBusyN),
    .resultBus(i_sac_link_if.resultBus), .resultOe(i_sac_link_if.resultOe));

  // Clock
  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic print_verdict();
    $display("Counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Level of a watched signal, by index
  function automatic logic watch(input int which);
    case (which)
      0: return hostReady;
      1: return i_sac_link_if.convBusyN;
      default: return wordValid;
    endcase
  endfunction : watch

  // Bounded wait for a level at a negedge
  task automatic wait_for(input int which, input logic lvl, input int bound);
    int n;
    n = 0;
    while (watch(which) !== lvl)
    begin
      @(negedge sys_clk);
      n++;
      if (n > bound)
      begin
        err_total++;
        print_verdict();
      end
    end
  endtask : wait_for

  // One start, conversion and read through the host end
  task automatic convert(input logic mode2, input logic bytes, input logic [15:0] value);
    int busyLen;
    @(negedge sys_clk);
    sampleIn = value;
    useCsMode = mode2;
    byteRead = bytes;
    wait_for(0, 1'b1, 500);
    startReq = 1'b1;
    @(negedge sys_clk);
    startReq = 1'b0;
    wait_for(1, 1'b0, 50);
    chk16({15'h0000, i_sac_link_if.resultOe}, 16'h0000);
    chk16({15'h0000, convActive}, 16'h0001);
    busyLen = 0;
    while (i_sac_link_if.convBusyN === 1'b0 && busyLen < 1000)
    begin
      @(negedge sys_clk);
      busyLen++;
    end
    chk16(16'(busyLen), CONV_LEN);
    wait_for(2, 1'b1, 50);
    chk16({15'h0000, convActive}, 16'h0000);
    chk16(sampleWord, value);
    chk16(lastResult, value);
  endtask : convert

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    sampleIn = 16'h0000;
    startReq = 1'b0;
    useCsMode = 1'b0;
    byteRead = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    convert(1'b0, 1'b0, 16'h1234);
    chk16(i_sac_link_if.resultBus, 16'h1234);
    chk16({15'h0000, i_sac_link_if.resultOe}, 16'h0001);
    convert(1'b0, 1'b1, 16'h7FFE);
    convert(1'b1, 1'b0, 16'hFFFF);
    convert(1'b1, 1'b0, 16'h0000);
    convert(1'b1, 1'b1, 16'h8001);
    convert(1'b0, 1'b0, 16'h8000);
    print_verdict();
  end
endmodule : tb_sar_adc_conversion_read_control

`default_nettype wire
